//--- rtl/disc_drive_control_interface.sv
`timescale 1ns/1ns
`include "disc_drive_cfg.svh"

module disc_drive_control_interface (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       powerup_reset,
	input  wire logic       supply_good,
	input  wire logic       load_command_strobe_n,
	input  wire logic       head_actuate_cmd_n,
	input  wire logic       phase_a_cmd,
	input  wire logic       phase_b_cmd,
	input  wire logic       door_lock_cmd_n,
	input  wire logic       head_one_select_cmd,
	input  wire logic       spin_flag_strobe,
	input  wire logic       write_request_n,
	input  wire logic       unit_code_bit0,
	input  wire logic       unit_code_bit1,
	input  wire logic       unit_code_bit2,
	input  wire logic       unit_code_valid_n,
	input  wire logic [2:0] unit_id_switch,
	input  wire logic       unit_id_present,
	input  wire logic       door_closed_sw_n,
	input  wire logic       door_open_sw_n,
	input  wire logic       protect_tab_sense,
	input  wire logic       home_track_raw,
	input  wire logic       rev_pulse_single_sided_n,
	input  wire logic       rev_pulse_double_sided_n,
	input  wire logic       heads_loaded,
	input  wire logic       single_sided_disc,
	input  wire logic       read_data,
	input  wire logic       serial_data_pos_i,
	input  wire logic       serial_data_neg_i,
	output logic            serial_data_pos_o,
	output logic            serial_data_neg_o,
	output logic            serial_data_oe,
	output logic            write_data,
	output logic            write_gate,
	output logic            read_enable,
	output logic            drive_ready_status,
	output logic            home_track_status_n,
	output logic            rev_pulse_out_n,
	output logic            spin_status_out_n,
	output logic            protect_status_n,
	output logic            door_closed,
	output logic            unit_selected_out,
	output logic            head_select,
	output logic            head_load_req,
	output logic            door_lock_drive,
	output logic [3:0]      stepper_coils,
	output logic [1:0]      drive_mode
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [`SYNC_W-1:0]         raw_in;
	logic [`SYNC_W-1:0]         syn;
	disc_drive_pkg::cmd_latch_s latch_r;
	disc_drive_pkg::cmd_latch_s latch_nxt;
	disc_drive_pkg::mode_e      mode_r;
	disc_drive_pkg::mode_e      mode_nxt;
	disc_drive_pkg::status_s    status_nxt;
	logic                       load_prev_r;
	logic                       load_edge;
	logic                       por;
	logic                       write_req;
	logic                       unit_selected;
	logic [2:0]                 own_id;
	logic                       door_r;
	logic                       rev_pulse_combined;
	logic                       disc_turning;
	logic                       spin_status_internal;
	logic                       ready;
	logic                       track_unique;
	logic                       write_ok;
	logic                       read_ok;
	logic [3:0]                 coils_nxt;

	// True when the code matches the identity and is validated
	function automatic logic unit_match(input logic [2:0] code, input logic [2:0] id, input logic valid);
		unit_match = valid && (code == id);
	endfunction

	// ****************************************
	// Input synchronisation
	// ****************************************

	// Gather every outside line except serial_data_neg_i into one bank
	always_comb begin
		raw_in                  = '0;
		raw_in[`SYN_LOAD_N]     = load_command_strobe_n;
		raw_in[`SYN_HDACT_N]    = head_actuate_cmd_n;
		raw_in[`SYN_PHASE_A]    = phase_a_cmd;
		raw_in[`SYN_PHASE_B]    = phase_b_cmd;
		raw_in[`SYN_DLOCK_N]    = door_lock_cmd_n;
		raw_in[`SYN_HEAD_ONE]   = head_one_select_cmd;
		raw_in[`SYN_SPIN_STB]   = spin_flag_strobe;
		raw_in[`SYN_WRITE_N]    = write_request_n;
		raw_in[`SYN_CODE0]      = unit_code_bit0;
		raw_in[`SYN_CODE1]      = unit_code_bit1;
		raw_in[`SYN_CODE2]      = unit_code_bit2;
		raw_in[`SYN_VALID_N]    = unit_code_valid_n;
		raw_in[`SYN_POR]        = powerup_reset;
		raw_in[`SYN_PGOOD]      = supply_good;
		raw_in[`SYN_CLOSED_N]   = door_closed_sw_n;
		raw_in[`SYN_OPEN_N]     = door_open_sw_n;
		raw_in[`SYN_PROTECT]    = protect_tab_sense;
		raw_in[`SYN_TRK_RAW]    = home_track_raw;
		raw_in[`SYN_IDX_SS_N]   = rev_pulse_single_sided_n;
		raw_in[`SYN_IDX_DS_N]   = rev_pulse_double_sided_n;
		raw_in[`SYN_LOADED]     = heads_loaded;
		raw_in[`SYN_SS_DISC]    = single_sided_disc;
		raw_in[`SYN_DATA_IN]    = serial_data_pos_i;
		raw_in[`SYN_RD_DATA]    = read_data;
		raw_in[`SYN_SW0]        = unit_id_switch[0];
		raw_in[`SYN_SW1]        = unit_id_switch[1];
		raw_in[`SYN_SW2]        = unit_id_switch[2];
		raw_in[`SYN_SW_PRESENT] = unit_id_present;
	end

	// Two-stage synchroniser bank
	sync_bank u_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (raw_in),
		.sync_out (syn)
	);

	// ****************************************
	// Selection and mode
	// ****************************************

	// Absent switch reads as identity zero
	assign own_id = syn[`SYN_SW_PRESENT] ? syn[`SYN_SW2:`SYN_SW0] : `DEFAULT_ID;

	// Comparator against the unit code
	assign unit_selected = unit_match(syn[`SYN_CODE2:`SYN_CODE0], own_id, ~syn[`SYN_VALID_N]);

	assign por       = syn[`SYN_POR];
	assign write_req = ~syn[`SYN_WRITE_N];

	// Mode follows write request; idle while not selected
	always_comb begin
		mode_nxt = disc_drive_pkg::MODE_IDLE;
		case ({unit_selected, write_req})
			2'b11:   mode_nxt = disc_drive_pkg::MODE_WRITE;
			2'b10:   mode_nxt = disc_drive_pkg::MODE_READ;
			default: mode_nxt = disc_drive_pkg::MODE_IDLE;
		endcase
	end

	// Mode register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_r <= disc_drive_pkg::MODE_IDLE;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// ****************************************
	// Command latch
	// ****************************************

	// Strobe assertion edge
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			load_prev_r <= 1'b0;
		end else begin
			load_prev_r <= ~syn[`SYN_LOAD_N];
		end
	end

	assign load_edge = ~syn[`SYN_LOAD_N] & ~load_prev_r;

	// Next latch contents, inverted active-low commands
	always_comb begin
		latch_nxt.head_actuate = ~syn[`SYN_HDACT_N];
		latch_nxt.phase_a      = syn[`SYN_PHASE_A];
		latch_nxt.phase_b      = syn[`SYN_PHASE_B];
		latch_nxt.door_lock    = ~syn[`SYN_DLOCK_N];
		latch_nxt.head_one     = syn[`SYN_HEAD_ONE];
	end

	// Capture gated by selection and read mode; reset clears
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			latch_r <= `LATCH_RST;
		end else if (por) begin
			latch_r <= `LATCH_RST;
		end else if (load_edge && unit_selected && !write_req) begin
			latch_r <= latch_nxt;
		end
	end

	// ****************************************
	// Sensors
	// ****************************************

	// Door flip-flop; open wins when both lines are low
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			door_r <= 1'b0;
		end else if (!syn[`SYN_OPEN_N]) begin
			door_r <= 1'b0;
		end else if (!syn[`SYN_CLOSED_N]) begin
			door_r <= 1'b1;
		end
	end

	// Either index sensor gives the revolution pulse
	assign rev_pulse_combined = ~syn[`SYN_IDX_SS_N] | ~syn[`SYN_IDX_DS_N];

	// Index counter and spin flag
	spin_counter u_spin (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.clear        (por | ~door_r),
		.rev_pulse    (rev_pulse_combined),
		.strobe       (syn[`SYN_SPIN_STB]),
		.disc_turning (disc_turning),
		.spin_flag    (spin_status_internal)
	);

	// Raw sensor covers tracks -01..01; phases make it unique
	assign track_unique = syn[`SYN_TRK_RAW] & latch_r.phase_a & latch_r.phase_b;

	// Ready and transfer enables
	assign ready    = spin_status_internal & unit_selected & syn[`SYN_LOADED]
	                  & ~(latch_r.head_one & syn[`SYN_SS_DISC]);
	assign read_ok  = ready & ~write_req;
	assign write_ok = syn[`SYN_PGOOD] & unit_selected & ready & write_req
	                  & ~syn[`SYN_PROTECT];

	// Four-phase coil pattern from latched phases, off while head_actuate is clear
	assign coils_nxt = latch_r.head_actuate
	                   ? {~latch_r.phase_b, ~latch_r.phase_a, latch_r.phase_b, latch_r.phase_a}
	                   : `COILS_OFF;

	// Status bundle
	always_comb begin
		status_nxt.ready      = ready;
		status_nxt.home_track = track_unique;
		status_nxt.rev_pulse  = rev_pulse_combined;
		status_nxt.spinning   = spin_status_internal;
		status_nxt.protect    = syn[`SYN_PROTECT];
	end

	// ****************************************
	// Registered outputs
	// ****************************************

	// Status toward the controller
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			drive_ready_status  <= 1'b0;
			home_track_status_n <= 1'b1;
			rev_pulse_out_n     <= 1'b1;
			spin_status_out_n   <= 1'b1;
			protect_status_n    <= 1'b1;
			door_closed         <= 1'b0;
			unit_selected_out   <= 1'b0;
			drive_mode          <= 2'h0;
		end else begin
			drive_ready_status  <= status_nxt.ready;
			home_track_status_n <= ~status_nxt.home_track;
			rev_pulse_out_n     <= ~status_nxt.rev_pulse;
			spin_status_out_n   <= ~status_nxt.spinning;
			protect_status_n    <= ~status_nxt.protect;
			door_closed         <= door_r;
			unit_selected_out   <= unit_selected;
			drive_mode          <= mode_r;
		end
	end

	// Actuators from the latch
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			head_select     <= 1'b0;
			head_load_req   <= 1'b0;
			door_lock_drive <= 1'b0;
			stepper_coils   <= `COILS_OFF;
		end else begin
			head_select     <= latch_r.head_one;
			head_load_req   <= latch_r.head_actuate & disc_turning;
			door_lock_drive <= latch_r.door_lock | latch_r.head_actuate;
			stepper_coils   <= coils_nxt;
		end
	end

	// Data pair: out on read, in on write
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			read_enable       <= 1'b0;
			write_gate        <= 1'b0;
			serial_data_oe    <= 1'b0;
			serial_data_pos_o <= 1'b0;
			serial_data_neg_o <= 1'b1;
			write_data        <= 1'b0;
		end else begin
			read_enable       <= read_ok;
			write_gate        <= write_ok;
			serial_data_oe    <= read_ok;
			serial_data_pos_o <= syn[`SYN_RD_DATA];
			serial_data_neg_o <= ~syn[`SYN_RD_DATA];
			write_data        <= write_ok & syn[`SYN_DATA_IN];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_head_select_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		head_select == $past(latch_r.head_one))
		else $error("head select does not follow latch");

	a_latch_gated_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!por && (!load_edge || !unit_selected || write_req)) |=> $stable(latch_r))
		else $error("latch changed without a gated load");

	a_latch_takes_cmd: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!por && load_edge && unit_selected && !write_req) |=> latch_r == $past(latch_nxt))
		else $error("latch missed a gated load");

	a_coils_phase: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$past(latch_r.head_actuate) |-> stepper_coils[1:0] == {$past(latch_r.phase_b), $past(latch_r.phase_a)})
		else $error("coils do not match phases");

	a_write_gate_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
		write_gate |-> $past(syn[`SYN_PGOOD] && unit_selected && ready && write_req && !syn[`SYN_PROTECT]))
		else $error("write gate without all conditions");

	a_por_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
		por |=> (latch_r == `LATCH_RST && !spin_status_internal) ##1 stepper_coils == `COILS_OFF)
		else $error("power-up reset did not clear");

	a_spin_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(syn[`SYN_SPIN_STB] && !$past(syn[`SYN_SPIN_STB]) && !por && door_r)
		|=> spin_status_internal == $past(disc_turning))
		else $error("spin flag not loaded on strobe");

	a_mode_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(unit_selected && write_req) |=> mode_r == disc_drive_pkg::MODE_WRITE)
		else $error("write mode not entered");

	a_pair_direction: assert property (@(posedge sys_clk) disable iff (sys_rst)
		serial_data_oe |-> !write_gate)
		else $error("pair driven while writing");

	a_home_track_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
		home_track_status_n == !$past(syn[`SYN_TRK_RAW] && latch_r.phase_a && latch_r.phase_b))
		else $error("home track status wrong");

	a_select_match: assert property (@(posedge sys_clk) disable iff (sys_rst)
		unit_selected |-> (!syn[`SYN_VALID_N] && syn[`SYN_CODE2:`SYN_CODE0] == own_id))
		else $error("selected without a match");

	a_default_id: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!syn[`SYN_SW_PRESENT] |-> own_id == `DEFAULT_ID)
		else $error("identity not zero without switch");

	a_door_open_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!syn[`SYN_OPEN_N] |=> !door_r ##1 !door_closed)
		else $error("door flag not cleared");

	a_protect_blocks: assert property (@(posedge sys_clk) disable iff (sys_rst)
		syn[`SYN_PROTECT] |=> !write_gate)
		else $error("write gate open with protect");

	a_index_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rev_pulse_out_n == !$past(rev_pulse_combined))
		else $error("index out not inverted or");

	a_ready_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
		drive_ready_status |-> $past(spin_status_internal && unit_selected && syn[`SYN_LOADED]))
		else $error("ready without its conditions");

	a_read_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
		read_enable == $past(ready && !write_req))
		else $error("read enable wrong");

endmodule

//--- rtl/disc_drive_cfg.svh
`ifndef DISC_DRIVE_CFG_SVH
`define DISC_DRIVE_CFG_SVH

// ****************************************
// Synchroniser bank bit positions
// ****************************************
`define SYN_LOAD_N     0
`define SYN_HDACT_N    1
`define SYN_PHASE_A    2
`define SYN_PHASE_B    3
`define SYN_DLOCK_N    4
`define SYN_HEAD_ONE   5
`define SYN_SPIN_STB   6
`define SYN_WRITE_N    7
`define SYN_CODE0      8
`define SYN_CODE1      9
`define SYN_CODE2      10
`define SYN_VALID_N    11
`define SYN_POR        12
`define SYN_PGOOD      13
`define SYN_CLOSED_N   14
`define SYN_OPEN_N     15
`define SYN_PROTECT    16
`define SYN_TRK_RAW    17
`define SYN_IDX_SS_N   18
`define SYN_IDX_DS_N   19
`define SYN_LOADED     20
`define SYN_SS_DISC    21
`define SYN_DATA_IN    22
`define SYN_RD_DATA    23
`define SYN_SW0        24
`define SYN_SW1        25
`define SYN_SW2        26
`define SYN_SW_PRESENT 27
`define SYNC_W         28
// Active-low lines idle high through reset
`define SYNC_RST       28'h00CC893

// ****************************************
// Reset values and counts
// ****************************************
`define LATCH_RST      5'h00
`define DEFAULT_ID     3'h0
`define INDEX_FULL     2'h2
`define INDEX_ZERO     2'h0
`define COILS_OFF      4'h0

`endif

//--- rtl/disc_drive_pkg.sv
package disc_drive_pkg;

	// Command latch contents, active high inside
	typedef struct packed {
		logic head_actuate;
		logic phase_a;
		logic phase_b;
		logic door_lock;
		logic head_one;
	} cmd_latch_s;

	// Transfer direction of the drive
	typedef enum logic [1:0] {
		MODE_IDLE  = 2'b00,
		MODE_READ  = 2'b01,
		MODE_WRITE = 2'b11
	} mode_e;

	// Status bundle toward the controller
	typedef struct packed {
		logic ready;
		logic home_track;
		logic rev_pulse;
		logic spinning;
		logic protect;
	} status_s;

endpackage

//--- rtl/sync_bank.sv
`timescale 1ns/1ns
`include "disc_drive_cfg.svh"

module sync_bank #(
	parameter int               WIDTH   = `SYNC_W,
	parameter logic [WIDTH-1:0] RST_VAL = `SYNC_RST
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// ****************************************
	// Two flip-flops per line
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// First stage feeds only the second
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta_r[i]   <= RST_VAL[i];
					sync_out[i] <= RST_VAL[i];
				end else begin
					meta_r[i]   <= async_in[i];
					sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule

//--- rtl/spin_counter.sv
`timescale 1ns/1ns
`include "disc_drive_cfg.svh"

module spin_counter (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic clear,
	input  wire logic rev_pulse,
	input  wire logic strobe,
	output logic      disc_turning,
	output logic      spin_flag
);

	logic [1:0] count_r;
	logic       rev_prev_r;
	logic       stb_prev_r;
	logic       rev_edge;
	logic       stb_edge;

	// Edge detectors on synchronised levels
	assign rev_edge = rev_pulse & ~rev_prev_r;
	assign stb_edge = strobe & ~stb_prev_r;

	// Previous levels
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rev_prev_r <= 1'b0;
			stb_prev_r <= 1'b0;
		end else begin
			rev_prev_r <= rev_pulse;
			stb_prev_r <= strobe;
		end
	end

	// Two successive index pulses mark a turning disc
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_r <= `INDEX_ZERO;
		end else if (clear) begin
			count_r <= `INDEX_ZERO;
		end else if (rev_edge && count_r != `INDEX_FULL) begin
			count_r <= count_r + 2'h1;
		end
	end

	assign disc_turning = (count_r == `INDEX_FULL);

	// Spin flag loads counter output on the strobe
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			spin_flag <= 1'b0;
		end else if (clear) begin
			spin_flag <= 1'b0;
		end else if (stb_edge) begin
			spin_flag <= disc_turning;
		end
	end

endmodule

//--- bench/ctrl_model.sv
`timescale 1ns/1ns

// ****************************************
// Controller side of the data pair
// ****************************************
module ctrl_model (
	input  wire logic sys_clk,
	input  wire logic write_request_n,
	input  wire logic wr_bit,
	input  wire logic serial_data_pos_o,
	input  wire logic serial_data_neg_o,
	input  wire logic serial_data_oe,
	output logic      serial_data_pos_i,
	output logic      serial_data_neg_i,
	output logic      rd_bit
);
	logic last_r = 1'h0;

	// Wire level: drive outward on read, controller drives on write, else junk
	always_comb begin
		if (serial_data_oe) begin
			serial_data_pos_i = serial_data_pos_o;
			serial_data_neg_i = serial_data_neg_o;
		end else if (!write_request_n) begin
			serial_data_pos_i = wr_bit;
			serial_data_neg_i = ~wr_bit;
		end else begin
			serial_data_pos_i = ~last_r;
			serial_data_neg_i = last_r;
		end
	end

	// Released pair toggles every cycle
	always @(posedge sys_clk) begin
		last_r <= serial_data_pos_i;
	end

	assign rd_bit = serial_data_pos_i; // Controller receiver
endmodule

//--- bench/tb.sv
`timescale 1ns/1ns

module tb;
	// ****************************************
	// Signals
	// ****************************************
	logic sys_clk = 1'h0, sys_rst = 1'h1, powerup_reset = 1'h0, supply_good = 1'h0;
	logic load_command_strobe_n = 1'h1, head_actuate_cmd_n = 1'h1, door_lock_cmd_n = 1'h1;
	logic phase_a_cmd = 1'h0, phase_b_cmd = 1'h0, head_one_select_cmd = 1'h0, spin_flag_strobe = 1'h0;
	logic write_request_n = 1'h1, unit_code_valid_n = 1'h1, unit_id_present = 1'h0;
	logic unit_code_bit0 = 1'h0, unit_code_bit1 = 1'h0, unit_code_bit2 = 1'h0;
	logic [2:0] unit_id_switch = 3'h0;
	logic door_closed_sw_n = 1'h1, door_open_sw_n = 1'h1, protect_tab_sense = 1'h0, home_track_raw = 1'h0;
	logic rev_pulse_single_sided_n = 1'h1, rev_pulse_double_sided_n = 1'h1;
	logic heads_loaded = 1'h0, single_sided_disc = 1'h0, read_data = 1'h0, wr_bit = 1'h1, rd_bit;
	logic serial_data_pos_i, serial_data_neg_i, serial_data_pos_o, serial_data_neg_o, serial_data_oe;
	logic write_data, write_gate, read_enable, drive_ready_status, home_track_status_n, rev_pulse_out_n;
	logic spin_status_out_n, protect_status_n, door_closed, unit_selected_out, head_select;
	logic head_load_req, door_lock_drive;
	logic [3:0] stepper_coils;
	logic [1:0] drive_mode;
	int error_cnt = 0;
	int compares = 0;

	disc_drive_control_interface i_disc_drive_control_interface (.*);

	ctrl_model i_ctrl_model (
		.sys_clk           (sys_clk),
		.write_request_n   (write_request_n),
		.wr_bit            (wr_bit),
		.serial_data_pos_o (serial_data_pos_o),
		.serial_data_neg_o (serial_data_neg_o),
		.serial_data_oe    (serial_data_oe),
		.serial_data_pos_i (serial_data_pos_i),
		.serial_data_neg_i (serial_data_neg_i),
		.rd_bit            (rd_bit)
	);

	// Clock, 8 ns period
	always #4 sys_clk = ~sys_clk;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One index pulse on either sensor line
	task automatic idx(input bit ds);
		if (ds) rev_pulse_double_sided_n <= 1'h0;
		else rev_pulse_single_sided_n <= 1'h0;
		wait_cyc(6);
		chk(rev_pulse_out_n, 4'h0);
		rev_pulse_double_sided_n <= 1'h1;
		rev_pulse_single_sided_n <= 1'h1;
		wait_cyc(6);
	endtask

	// Command load with the load strobe
	task automatic load_cmd;
		load_command_strobe_n <= 1'h0;
		wait_cyc(4);
		load_command_strobe_n <= 1'h1;
		wait_cyc(8);
	endtask

	task automatic conclude;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		wait_cyc(12);
		sys_rst <= 1'h0;
		wait_cyc(2);
		chk(spin_status_out_n, 4'h1);
		chk(head_select, 4'h0);
		chk(home_track_status_n, 4'h1);
		chk(drive_ready_status, 4'h0);
		unit_id_switch <= 3'h5;
		unit_id_present <= 1'h1;
		unit_code_bit0 <= 1'h1;
		unit_code_bit2 <= 1'h1;
		wait_cyc(8);
		chk(unit_selected_out, 4'h0);
		unit_code_valid_n <= 1'h0;
		wait_cyc(8);
		chk(unit_selected_out, 4'h1);
		chk(drive_mode, 4'h1);
		unit_id_present <= 1'h0;
		wait_cyc(8);
		chk(unit_selected_out, 4'h0);
		chk(drive_mode, 4'h0);
		unit_code_bit0 <= 1'h0;
		unit_code_bit2 <= 1'h0;
		write_request_n <= 1'h0;
		head_one_select_cmd <= 1'h1;
		head_actuate_cmd_n <= 1'h0;
		phase_a_cmd <= 1'h1;
		phase_b_cmd <= 1'h1;
		wait_cyc(8);
		chk(unit_selected_out, 4'h1);
		chk(drive_mode, 4'h3);
		load_cmd();
		chk(head_select, 4'h0);
		write_request_n <= 1'h1;
		wait_cyc(6);
		load_cmd();
		chk(head_select, 4'h1);
		chk(stepper_coils, 4'h3);
		chk(home_track_status_n, 4'h1);
		home_track_raw <= 1'h1;
		door_closed_sw_n <= 1'h0;
		wait_cyc(8);
		chk(home_track_status_n, 4'h0);
		chk(door_closed, 4'h1);
		idx(1'b0);
		idx(1'b1);
		chk(spin_status_out_n, 4'h1);
		spin_flag_strobe <= 1'h1;
		heads_loaded <= 1'h1;
		read_data <= 1'h1;
		wait_cyc(8);
		chk(spin_status_out_n, 4'h0);
		chk(drive_ready_status, 4'h1);
		chk(read_enable, 4'h1);
		chk(rd_bit, 4'h1);
		chk(serial_data_neg_o, 4'h0);
		chk(head_load_req, 4'h1);
		chk(door_lock_drive, 4'h1);
		read_data <= 1'h0;
		wait_cyc(8);
		chk(rd_bit, 4'h0);
		chk(serial_data_neg_o, 4'h1);
		spin_flag_strobe <= 1'h0;
		single_sided_disc <= 1'h1;
		wait_cyc(8);
		chk(drive_ready_status, 4'h0);
		single_sided_disc <= 1'h0;
		supply_good <= 1'h1;
		write_request_n <= 1'h0;
		wait_cyc(8);
		chk(write_gate, 4'h1);
		chk(serial_data_oe, 4'h0);
		chk(write_data, 4'h1);
		wr_bit <= 1'h0;
		wait_cyc(8);
		chk(write_data, 4'h0);
		protect_tab_sense <= 1'h1;
		wait_cyc(8);
		chk(write_gate, 4'h0);
		chk(protect_status_n, 4'h0);
		protect_tab_sense <= 1'h0;
		supply_good <= 1'h0;
		wait_cyc(8);
		chk(write_gate, 4'h0);
		write_request_n <= 1'h1;
		powerup_reset <= 1'h1;
		door_open_sw_n <= 1'h0;
		wait_cyc(8);
		chk(head_select, 4'h0);
		chk(stepper_coils, 4'h0);
		chk(spin_status_out_n, 4'h1);
		chk(door_closed, 4'h0);
		chk(head_load_req, 4'h0);
		chk(door_lock_drive, 4'h0);
		powerup_reset <= 1'h0;
		conclude();
	end

	// Watchdog well beyond the expected run
	initial begin
		wait_cyc(5000);
		error_cnt++;
		conclude();
	end
endmodule
